// File: urv_dev.sv
/*
 USB register bank end: control, status, target registers, the byte map
 with word remapping, the indexed registers and a small IN fifo.
 Assumes the core end keeps the loading order for burst access.
*/
`timescale 1ns/1ps
`default_nettype none
module urv_dev
   import urv_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        resetn_i,
   // Bus port
   urv_if.dev               bus,
   // USB side
   input  wire logic [10:0] frame_number_i,
   input  wire logic [7:0]  bus_event_set_i,
   input  wire logic        fifo_pop_i,
   output logic [15:0]      fifo_data_o,
   output logic             fifo_valid_o
);
   localparam int NREG = 32;
   localparam int NIDX = 9;
   logic [7:0]  regs [NREG];
   logic [7:0]  next_regs [NREG];
   logic [7:0]  ep_regs [3][NIDX];
   logic [7:0]  next_ep_regs [3][NIDX];
   logic [15:0] ctl, next_ctl;
   logic [5:0]  tgt, next_tgt;
   logic [15:0] fifo_mem [FIFO_DEPTH];
   logic [15:0] next_fifo_mem [FIFO_DEPTH];
   logic [3:0]  count, next_count;
   logic [2:0]  rd_ptr, next_rd_ptr, wr_ptr, next_wr_ptr;
   logic [15:0] rdata, next_rdata;
   logic [1:0]  ep;
   logic        fifo_push;

   assign ep = ctl[CTL_EP_LSB +: 2];
   assign bus.ctl_rdata = ctl;
   assign bus.sts_rdata = {15'h0000, count == 4'h0};
   assign bus.acc_rdata = rdata;
   assign bus.acc_be    = ctl[CTL_BYTE_BIT] ? BE_BYTE : BE_WORD;
   assign fifo_data_o   = fifo_mem[rd_ptr];
   assign fifo_valid_o  = count != 4'h0;
   // In burst mode the fifo push decodes the target register instead of the access address
   assign fifo_push     = bus.acc_valid && bus.acc_write && ctl[CTL_ENABLE_BIT]
                          && (ctl[CTL_BURST_BIT] ? tgt : bus.acc_addr) == ADDR_IN_FIFO
                          && count != 4'h8;

   function automatic logic is_indexed(input logic [5:0] a);
      is_indexed = a >= ADDR_IN_MAXP_LO && a <= ADDR_INDEX_LAST;
   endfunction

   function automatic logic [7:0] byte_mask(input logic [5:0] a);
      case (a)
         ADDR_IN_IRQ, ADDR_IN_IRQ_EN:   byte_mask = MSK_IN_IRQ;
         ADDR_OUT_IRQ, ADDR_OUT_IRQ_EN: byte_mask = MSK_OUT_IRQ;
         ADDR_BUS_IRQ, ADDR_BUS_IRQ_EN: byte_mask = MSK_BUS_IRQ;
         ADDR_IN_MAXP_HI:               byte_mask = MSK_MAXP_HI;
         ADDR_FRAME_LO, ADDR_FRAME_HI:  byte_mask = 8'h00;
         6'h0e, 6'h0f:                  byte_mask = 8'h00;
         default:                       byte_mask = 8'hff;
      endcase
   endfunction

   // Byte read through the remapped little-endian map
   function automatic logic [7:0] rd_byte(input logic [5:0] a, input logic [1:0] e,
                                          input logic [7:0] r [NREG],
                                          input logic [7:0] x [3][NIDX], input logic [10:0] fn);
      if (a == ADDR_FRAME_LO) begin
         rd_byte = fn[7:0];
      end else if (a == ADDR_FRAME_HI) begin
         rd_byte = {5'h00, fn[10:8]};
      end else if (is_indexed(a)) begin
         rd_byte = (e == 2'h3) ? 8'h00 : x[e][a[3:0]];
      end else if (a < 6'h20) begin
         rd_byte = r[a[4:0]] & byte_mask(a);
      end else begin
         rd_byte = 8'h00;
      end
   endfunction

   always_comb begin
      logic [5:0] a1;
      logic       hit;
      a1           = 6'h00;
      hit          = 1'b0;
      next_ctl     = bus.ctl_we ? bus.ctl_wdata : ctl;
      // Width and burst bits cannot be set while enabled, only cleared
      if (bus.ctl_we && ctl[CTL_ENABLE_BIT]) begin
         next_ctl[CTL_BYTE_BIT]  = ctl[CTL_BYTE_BIT] & bus.ctl_wdata[CTL_BYTE_BIT];
         next_ctl[CTL_BURST_BIT] = ctl[CTL_BURST_BIT] & bus.ctl_wdata[CTL_BURST_BIT];
      end
      next_tgt     = (bus.tgt_we && count == 4'h0) ? bus.tgt_wdata : tgt;
      next_regs    = regs;
      next_ep_regs = ep_regs;
      next_rdata   = rdata;
      a1           = bus.acc_addr + 6'h01;
      if (bus.acc_valid) begin
         hit = bus.acc_addr < 6'h20 && ep != 2'h3;
         if (bus.acc_write) begin
            // Low byte to address N, high byte to N+1 in word mode
            if (is_indexed(bus.acc_addr)) begin
               if (hit) next_ep_regs[ep][bus.acc_addr[3:0]] = bus.acc_wdata[7:0] & byte_mask(bus.acc_addr);
            end else if (bus.acc_addr < 6'h20) begin
               next_regs[bus.acc_addr[4:0]] = bus.acc_wdata[7:0] & byte_mask(bus.acc_addr);
            end
            if (!ctl[CTL_BYTE_BIT] && a1 < 6'h20) begin
               if (is_indexed(a1)) begin
                  if (ep != 2'h3) next_ep_regs[ep][a1[3:0]] = bus.acc_wdata[15:8] & byte_mask(a1);
               end else begin
                  next_regs[a1[4:0]] = bus.acc_wdata[15:8] & byte_mask(a1);
               end
            end
         end else begin
            // Word read pairs byte N+1 above byte N; 00h yields power:address
            next_rdata[7:0]  = rd_byte(bus.acc_addr, ep, regs, ep_regs, frame_number_i);
            next_rdata[15:8] = ctl[CTL_BYTE_BIT] ? 8'h00 :
                               rd_byte(a1, ep, regs, ep_regs, frame_number_i);
         end
      end
      // Hardware sets win over same-cycle software writes
      next_regs[ADDR_BUS_IRQ[4:0]] = next_regs[ADDR_BUS_IRQ[4:0]] | (bus_event_set_i & MSK_BUS_IRQ);
      next_fifo_mem = fifo_mem;
      next_wr_ptr   = wr_ptr;
      next_rd_ptr   = rd_ptr;
      next_count    = count;
      if (fifo_push) begin
         next_fifo_mem[wr_ptr] = ctl[CTL_BYTE_BIT] ? {8'h00, bus.acc_wdata[7:0]} : bus.acc_wdata;
         next_wr_ptr           = wr_ptr + 3'h1;
      end
      if (fifo_pop_i && count != 4'h0) next_rd_ptr = rd_ptr + 3'h1;
      next_count = count + {3'h0, fifo_push} - {3'h0, fifo_pop_i && count != 4'h0};
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < NREG; i++) regs[i] <= 8'h00;
         regs[ADDR_POWER[4:0]]      <= RST_POWER;
         regs[ADDR_IN_IRQ_EN[4:0]]  <= RST_IN_IRQ_EN;
         regs[ADDR_OUT_IRQ_EN[4:0]] <= RST_OUT_IRQ_EN;
         regs[ADDR_BUS_IRQ_EN[4:0]] <= RST_BUS_IRQ_EN;
         for (int e = 0; e < 3; e++) for (int j = 0; j < NIDX; j++) ep_regs[e][j] <= 8'h00;
         for (int k = 0; k < FIFO_DEPTH; k++) fifo_mem[k] <= 16'h0000;
         ctl    <= {6'h00, RST_EP_SELECT, 8'h00};
         tgt    <= 6'h00;
         rdata  <= 16'h0000;
         count  <= 4'h0;
         rd_ptr <= 3'h0;
         wr_ptr <= 3'h0;
      end else begin
         regs     <= next_regs;
         ep_regs  <= next_ep_regs;
         fifo_mem <= next_fifo_mem;
         ctl      <= next_ctl;
         tgt      <= next_tgt;
         rdata    <= next_rdata;
         count    <= next_count;
         rd_ptr   <= next_rd_ptr;
         wr_ptr   <= next_wr_ptr;
      end
   end
endmodule // urv_dev
`default_nettype wire

// File: urv_pkg.sv
/*
 Package for the USB register bank reached over the bus port.
 Holds register offsets, reset values, field positions and the states of
 the controller-side sequencer.
 Assumes one 100 MHz clock and an active-low asynchronous reset.
*/
package urv_pkg;
   // Byte addresses of the USB cell
   localparam logic [5:0] ADDR_FUNC_ADDR   = 6'h00;
   localparam logic [5:0] ADDR_POWER       = 6'h01;
   localparam logic [5:0] ADDR_IN_IRQ      = 6'h02;
   localparam logic [5:0] ADDR_OUT_IRQ     = 6'h04;
   localparam logic [5:0] ADDR_IN_IRQ_EN   = 6'h06;
   localparam logic [5:0] ADDR_OUT_IRQ_EN  = 6'h08;
   localparam logic [5:0] ADDR_BUS_IRQ     = 6'h0a;
   localparam logic [5:0] ADDR_BUS_IRQ_EN  = 6'h0b;
   localparam logic [5:0] ADDR_FRAME_LO    = 6'h0c;
   localparam logic [5:0] ADDR_FRAME_HI    = 6'h0d;
   localparam logic [5:0] ADDR_IN_MAXP_LO  = 6'h10;
   localparam logic [5:0] ADDR_IN_MAXP_HI  = 6'h11;
   localparam logic [5:0] ADDR_IN_CSR_LO   = 6'h12;
   localparam logic [5:0] ADDR_IN_CSR_HI   = 6'h13;
   localparam logic [5:0] ADDR_OUT_MAXP_LO = 6'h14;
   localparam logic [5:0] ADDR_INDEX_LAST  = 6'h18;
   localparam logic [5:0] ADDR_IN_FIFO     = 6'h21;
   // Reset values
   localparam logic [7:0] RST_POWER        = 8'h20;
   localparam logic [7:0] RST_IN_IRQ_EN    = 8'h07;
   localparam logic [7:0] RST_OUT_IRQ_EN   = 8'h06;
   localparam logic [7:0] RST_BUS_IRQ_EN   = 8'h06;
   localparam logic [1:0] RST_EP_SELECT    = 2'h2;
   // Write masks of implemented bits
   localparam logic [7:0] MSK_IN_IRQ       = 8'h07;
   localparam logic [7:0] MSK_OUT_IRQ      = 8'h06;
   localparam logic [7:0] MSK_BUS_IRQ      = 8'h0f;
   localparam logic [7:0] MSK_MAXP_HI      = 8'h07;
   // Control and status register fields
   localparam int         CTL_ENABLE_BIT   = 0;
   localparam int         CTL_BURST_BIT    = 1;
   localparam int         CTL_BYTE_BIT     = 2;
   localparam int         CTL_EP_LSB       = 8;
   localparam int         STS_EMPTY_BIT    = 0;
   // Values the controller side loads, block and fifo sizes, byte enable codes
   localparam logic [15:0] CTL_BURST_ON    = 16'h0003;
   localparam logic [5:0]  TARGET_IN_FIFO  = 6'h21;
   localparam int          BLOCK_WORDS     = 8;
   localparam int          FIFO_DEPTH      = 8;
   localparam logic [1:0]  BE_WORD         = 2'h3;
   localparam logic [1:0]  BE_BYTE         = 2'h1;

   typedef enum logic [4:0] {
      URV_IDLE  = 5'h01,
      URV_SETUP = 5'h02,
      URV_WAIT  = 5'h04,
      URV_BURST = 5'h08,
      URV_DONE  = 5'h10
   } urv_state_t;
endpackage

// File: urv_if.sv
/*
 Interface joining the USB register bank and the controller core.
 Carries control/status/target loads and the register access port.
 Assumes both ends share core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
interface urv_if;
   logic [15:0] ctl_wdata;
   logic        ctl_we;
   logic [5:0]  tgt_wdata;
   logic        tgt_we;
   logic [15:0] ctl_rdata;
   logic [15:0] sts_rdata;
   logic        acc_valid;
   logic        acc_write;
   logic [5:0]  acc_addr;
   logic [15:0] acc_wdata;
   logic [15:0] acc_rdata;
   logic [1:0]  acc_be;

   modport dev (input ctl_wdata, ctl_we, tgt_wdata, tgt_we, acc_valid, acc_write, acc_addr,
                acc_wdata, output ctl_rdata, sts_rdata, acc_rdata, acc_be);
   modport core (output ctl_wdata, ctl_we, tgt_wdata, tgt_we, acc_valid, acc_write, acc_addr,
                 acc_wdata, input ctl_rdata, sts_rdata, acc_rdata, acc_be);
endinterface
`default_nettype wire

// File: urv_core.sv
/*
 Controller-core end: on a start pulse it loads target and control for
 burst IN streaming, then writes blocks of words, waiting for fifo empty.
 Assumes the device end answers on the shared clock.
*/
`timescale 1ns/1ps
`default_nettype none
module urv_core
   import urv_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        resetn_i,
   // Bus port
   urv_if.core              bus,
   // User side
   input  wire logic        start_i,
   input  wire logic [1:0]  endpoint_i,
   input  wire logic [3:0]  blocks_i,
   input  wire logic [15:0] word_i,
   output logic             word_take_o,
   output logic             busy_o
);
   urv_state_t  state, next_state;
   logic [2:0]  widx, next_widx;
   logic [3:0]  left, next_left;

   assign busy_o      = state != URV_IDLE;
   assign word_take_o = state == URV_BURST;

   always_comb begin
      next_state     = state;
      next_widx      = widx;
      next_left      = left;
      bus.ctl_we     = 1'b0;
      bus.ctl_wdata  = 16'h0000;
      bus.tgt_we     = 1'b0;
      bus.tgt_wdata  = 6'h00;
      bus.acc_valid  = 1'b0;
      bus.acc_write  = 1'b0;
      bus.acc_addr   = TARGET_IN_FIFO;
      bus.acc_wdata  = word_i;
      case (state)
         URV_IDLE: begin
            if (start_i && blocks_i != 4'h0) begin
               bus.tgt_we    = 1'b1;
               bus.tgt_wdata = TARGET_IN_FIFO;
               next_left     = blocks_i;
               next_state    = URV_SETUP;
            end
         end
         URV_SETUP: begin
            bus.ctl_we    = 1'b1;
            bus.ctl_wdata = CTL_BURST_ON | {6'h00, endpoint_i, 8'h00};
            next_state    = URV_WAIT;
         end
         URV_WAIT: begin
            if (bus.sts_rdata[STS_EMPTY_BIT]) begin
               next_widx  = 3'h0;
               next_state = URV_BURST;
            end
         end
         URV_BURST: begin
            bus.acc_valid = 1'b1;
            bus.acc_write = 1'b1;
            next_widx     = widx + 3'h1;
            if (widx == 3'(BLOCK_WORDS - 1)) begin
               next_left  = left - 4'h1;
               next_state = (left == 4'h1) ? URV_DONE : URV_WAIT;
            end
         end
         URV_DONE: begin
            if (bus.sts_rdata[STS_EMPTY_BIT]) begin
               bus.ctl_we    = 1'b1;
               bus.ctl_wdata = {6'h00, endpoint_i, 8'h00};
               next_state    = URV_IDLE;
            end
         end
         default: next_state = URV_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= URV_IDLE;
         widx  <= 3'h0;
         left  <= 4'h0;
      end else begin
         state <= next_state;
         widx  <= next_widx;
         left  <= next_left;
      end
   end
endmodule // urv_core
`default_nettype wire

// File: urv_asserts.sv
/*
 Checker for the bus between the USB register bank end and the controller end.
 Assumes the testbench instantiates it beside the interface, on core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module urv_asserts (
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        resetn_i,
   // Interface signals
   input  wire logic [15:0] ctl_wdata,
   input  wire logic        ctl_we,
   input  wire logic [5:0]  tgt_wdata,
   input  wire logic        tgt_we,
   input  wire logic [15:0] ctl_rdata,
   input  wire logic [15:0] sts_rdata,
   input  wire logic        acc_valid,
   input  wire logic        acc_write,
   input  wire logic [5:0]  acc_addr,
   input  wire logic [1:0]  acc_be
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   chk_be_width: assert property (acc_be == (ctl_rdata[2] ? 2'h1 : 2'h3))
      else $error("byte enables do not follow width bit");
   chk_mode_frozen: assert property (
      $past(ctl_rdata[0]) |-> (ctl_rdata[2:1] & ~$past(ctl_rdata[2:1])) == 2'h0)
      else $error("mode bits set while enabled");
   chk_ep_load: assert property (ctl_we |=> ctl_rdata[9:8] == $past(ctl_wdata[9:8]))
      else $error("endpoint select not loaded");
   chk_reset_ep: assert property ($rose(resetn_i) |-> ctl_rdata == 16'h0200 && sts_rdata[0])
      else $error("control or status wrong after reset");
   chk_target_in: assert property (tgt_we |-> tgt_wdata == 6'h21)
      else $error("target not the IN fifo");
   chk_burst_ctl: assert property (tgt_we |=> ctl_we && ctl_wdata[7:0] == 8'h03)
      else $error("burst enable not loaded after target");
   chk_wait_empty: assert property (acc_valid && !$past(acc_valid) |-> sts_rdata[0])
      else $error("block started with fifo not empty");
   chk_block_len: assert property ($rose(acc_valid) |-> acc_valid [*8] ##1 !acc_valid)
      else $error("block is not eight words");
   chk_empty_flag: assert property (acc_valid && acc_write && acc_addr == 6'h21 && ctl_rdata[0]
                                    |=> !sts_rdata[0])
      else $error("empty flag set after fifo write");
endmodule // urv_asserts
`default_nettype wire

// File: urv_tb.sv
/*
 Testbench: controller end streams into the bank end; a second bank end on its
 own interface is driven directly for register checks.
 Assumes 100 MHz core_clk_i and active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module urv_tb;
   import urv_pkg::*;
   logic        core_clk_i, resetn_i, start_i, fifo_pop_i, word_take_o, busy_o, fifo_valid_o;
   logic [1:0]  endpoint_i;
   logic [3:0]  blocks_i;
   logic [15:0] word_i, fifo_data_o, rd;
   logic [10:0] frame_number_i;
   logic [7:0]  ev_b;
   logic [15:0] got[$];
   int          n_errors, compares, cycles;

   urv_if bus_a();
   urv_if bus_b();
   urv_dev urv_dev_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .bus(bus_a),
      .frame_number_i(frame_number_i), .bus_event_set_i(8'h00), .fifo_pop_i(fifo_pop_i),
      .fifo_data_o(fifo_data_o), .fifo_valid_o(fifo_valid_o));
   urv_dev urv_dev_reg_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .bus(bus_b),
      .frame_number_i(frame_number_i), .bus_event_set_i(ev_b), .fifo_pop_i(1'b0),
      .fifo_data_o(), .fifo_valid_o());
   urv_core urv_core_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .bus(bus_a),
      .start_i(start_i), .endpoint_i(endpoint_i), .blocks_i(blocks_i), .word_i(word_i),
      .word_take_o(word_take_o), .busy_o(busy_o));
   urv_asserts urv_asserts_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
      .ctl_wdata(bus_a.ctl_wdata), .ctl_we(bus_a.ctl_we), .tgt_wdata(bus_a.tgt_wdata),
      .tgt_we(bus_a.tgt_we), .ctl_rdata(bus_a.ctl_rdata), .sts_rdata(bus_a.sts_rdata),
      .acc_valid(bus_a.acc_valid), .acc_write(bus_a.acc_write), .acc_addr(bus_a.acc_addr),
      .acc_be(bus_a.acc_be));

   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic ctl_wr(input logic [15:0] v);
      @(posedge core_clk_i);
      bus_b.ctl_we    <= 1'b1;
      bus_b.ctl_wdata <= v;
      @(posedge core_clk_i);
      bus_b.ctl_we    <= 1'b0;
      @(posedge core_clk_i);
      #1;
   endtask

   task automatic acc(input logic wr, input logic [5:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      bus_b.acc_valid <= 1'b1;
      bus_b.acc_write <= wr;
      bus_b.acc_addr  <= a;
      bus_b.acc_wdata <= d;
      @(posedge core_clk_i);
      bus_b.acc_valid <= 1'b0;
      @(posedge core_clk_i);
      #1;
      rd = bus_b.acc_rdata;
   endtask

   task automatic test_map();
      #1;
      chk("control", 16'h0200, bus_b.ctl_rdata);
      chk("status", 16'h0001, bus_b.sts_rdata);
      chk("byte enables", 16'h0003, {14'h0, bus_b.acc_be});
      acc(1'b0, 6'h00, 16'h0000);
      chk("word 00h", 16'h2000, rd);
      acc(1'b0, 6'h0a, 16'h0000);
      chk("word 0ah", 16'h0600, rd);
      acc(1'b0, 6'h0c, 16'h0000);
      chk("frame number", 16'h05a3, rd);
   endtask

   task automatic test_remap();
      acc(1'b1, 6'h00, 16'h2055);
      acc(1'b0, 6'h01, 16'h0000);
      chk("word 01h", 16'h0020, rd);
      acc(1'b1, 6'h0e, 16'hffff);
      acc(1'b0, 6'h0e, 16'h0000);
      chk("reserved 0eh", 16'h0000, rd);
      @(posedge core_clk_i);
      ev_b <= 8'h08;
      @(posedge core_clk_i);
      ev_b <= 8'h00;
      acc(1'b0, 6'h0a, 16'h0000);
      chk("bus event flags", 16'h0608, rd);
   endtask

   task automatic test_index();
      ctl_wr(16'h0100);
      acc(1'b1, 6'h10, 16'hffff);
      ctl_wr(16'h0200);
      acc(1'b0, 6'h10, 16'h0000);
      chk("max packet ep2", 16'h0000, rd);
      ctl_wr(16'h0100);
      acc(1'b0, 6'h10, 16'h0000);
      chk("max packet ep1", 16'h07ff, rd);
   endtask

   task automatic test_byte_mode();
      ctl_wr(16'h0004);
      chk("byte mode enables", 16'h0001, {14'h0, bus_b.acc_be});
      acc(1'b0, 6'h00, 16'h0000);
      chk("byte read 00h", 16'h0055, rd);
      ctl_wr(16'h0000);
      chk("word mode enables", 16'h0003, {14'h0, bus_b.acc_be});
      ctl_wr(16'h0001);
      ctl_wr(16'h0007);
      chk("mode held while enabled", 16'h0001, bus_b.ctl_rdata);
      ctl_wr(16'h0000);
   endtask

   task automatic test_stream();
      int i;
      @(posedge core_clk_i);
      start_i <= 1'b1;
      @(posedge core_clk_i);
      start_i <= 1'b0;
      @(posedge core_clk_i);
      #1;
      for (i = 0; i < 1000 && busy_o !== 1'b0; i++) begin
         @(posedge core_clk_i);
         #1;
      end
      repeat (4) @(posedge core_clk_i);
      #1;
      chk("words received", 16'd16, 16'(got.size()));
      for (i = 0; i < got.size(); i++)
         chk("stream word", 16'h1000 + 16'(i), got[i]);
      chk("control after stream", 16'h0100, {bus_a.ctl_rdata[15:1], 1'b0});
      chk("enable off", 16'h0000, {15'h0, bus_a.ctl_rdata[0]});
      chk("fifo empty", 16'h0001, {15'h0, bus_a.sts_rdata[0]});
   endtask

   task automatic end_sim();
      $display("Compares %0d, errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Slow USB side: pops at most every other cycle
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (word_take_o) word_i <= word_i + 16'h0001;
      if (fifo_pop_i && fifo_valid_o) got.push_back(fifo_data_o);
      fifo_pop_i <= fifo_valid_o && !fifo_pop_i;
      if (cycles == 4000) begin
         n_errors++;
         end_sim();
      end
   end

   initial begin
      resetn_i = 1'b0; start_i = 1'b0; fifo_pop_i = 1'b0; endpoint_i = 2'h1; blocks_i = 4'h2;
      word_i = 16'h1000; frame_number_i = 11'h5a3; ev_b = 8'h00; cycles = 0;
      n_errors = 0; compares = 0;
      bus_b.ctl_we = 1'b0; bus_b.ctl_wdata = 16'h0000; bus_b.tgt_we = 1'b0; bus_b.tgt_wdata = 6'h00;
      bus_b.acc_valid = 1'b0; bus_b.acc_write = 1'b0; bus_b.acc_addr = 6'h00; bus_b.acc_wdata = 16'h0000;
      repeat (4) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      test_map();
      test_remap();
      test_index();
      test_byte_mode();
      test_stream();
      end_sim();
   end
endmodule // urv_tb
`default_nettype wire
